// File: pkg/sdadc_params.svh
// offsets, field positions, reset values and counts of the converter control
// assumes inclusion by bare name from design and bench files
`ifndef SDADC_PARAMS_SVH
`define SDADC_PARAMS_SVH
`define SDADC_OFS_CTRL0   8'h00
`define SDADC_OFS_CTRL1   8'h01
`define SDADC_OFS_CLKSEL  8'h02
`define SDADC_OFS_RES_LO  8'h03
`define SDADC_OFS_RES_MID 8'h04
`define SDADC_OFS_RES_HI  8'h05
`define SDADC_OFS_PWR     8'h06
`define SDADC_OFS_CHAN    8'h07
`define SDADC_CTRL0_RST   8'h20
`define SDADC_CTRL0_MASK  8'hFD
`define SDADC_CTRL1_RST   8'h00
`define SDADC_CLKSEL_RST  5'h00
`define SDADC_PWR_RST     5'h00
`define SDADC_CHAN_RST    6'h00
`define SDADC_B_FRST      7
`define SDADC_B_SLP       6
`define SDADC_B_OFF       5
`define SDADC_B_OSR       2
`define SDADC_B_REFSEL    0
`define SDADC_B_NBUF      4
`define SDADC_B_PBUF      3
`define SDADC_B_HOLD      2
`define SDADC_B_DONE      1
`define SDADC_B_LDO       0
`define SDADC_B_VCM       1
`define SDADC_B_IE        2
`define SDADC_B_GIE       3
`define SDADC_B_IRQF      4
`define SDADC_B_CHN       3
`define SDADC_DIV_BYPASS  5'h1F
`define SDADC_OSR_MAX     15'h4000
`define SDADC_TEMP_CHAN   3'h7
`endif

// File: pkg/sdadc_pkg.sv
// types shared by the converter mode control
// assumes the params header is compiled alongside
package sdadc_pkg;
  typedef enum logic [3:0] {
    SDADC_PDN    = 4'h1,
    SDADC_SLEEP  = 4'h2,
    SDADC_NORMAL = 4'h4,
    SDADC_FRESET = 4'h8
  } sdadc_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sdadc_bus_t;
  typedef struct packed {
    logic bandgap;
    logic regulator;
    logic mid_ref;
    logic pga;
    logic modulator;
    logic temp_sensor;
    logic neg_buf;
    logic pos_buf;
    logic filter_en;
    logic filter_rst;
    logic ref_ext;
  } sdadc_power_t;
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [4:0]  clksel;
    logic [4:0]  pwr;
    logic [5:0]  chan;
    logic [23:0] result;
    logic [7:0]  rdata;
    logic [5:0]  div_cnt;
    logic [14:0] osr_cnt;
    logic        started;
    logic        frst_prev;
  } sdadc_state_t;
endpackage

// File: core/sdadc_mode_ctrl.sv
// mode decode, start sequence, conversion timing, result and clock divider
// assumes filter_word comes from the decimation datapath on sys_clk
//
// Overview of operation
// - power-off set forces power-down, analog and filter off except regulator and bandgap, which follow the LDO bit
// - sleep keeps bandgap, amplifier, filter on; modulator, mid ref, buffers off
// - all control bits clear gives normal continuous conversion; the code converts only after filter reset is cleared into normal mode
// - filter-reset alone holds filter in reset, discards running conversion
// - hardware sets done flag at each completed conversion outside hold
// - completion also sets the interrupt request flag
// - interrupt reaches processor only with global and converter enables set
// - results overwritten each conversion unless hold is enabled
// - master clock is system clock undivided or divided by five-bit code
// - one bit selects internal or external reference pair
// - with power-off set converter circuitry is unpowered but for regulator and bandgap under the LDO bit
// - result is 24-bit two's complement, sign in top bit
// - mid ref generator follows its enable in normal and reset only
// - temperature sensor on only when a channel field selects it
// - each reference buffer follows its own bit in normal and reset
// - done flag stays set until firmware writes zero
// - during hold no done flag and no interrupt
// - oversampling code 0 gives 16384, halving down to 128 at code 7
// - divider code n gives sys/2/(n+1), all ones passes sys through
//
// Chosen here: the register offsets and the address-and-strobe port.
`include "sdadc_params.svh"
module sdadc_mode_ctrl (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire sdadc_pkg::sdadc_bus_t bus,
  output logic [7:0]                rdata,
  input  wire logic [23:0]          filter_word,
  output logic                      mclk_tick,
  output sdadc_pkg::sdadc_power_t   power,
  output sdadc_pkg::sdadc_mode_t    mode,
  output logic [23:0]               result_word,
  output logic                      irq
);
  sdadc_pkg::sdadc_state_t s_q;
  sdadc_pkg::sdadc_state_t s_d;
  logic        off;
  logic        slp;
  logic        frst;
  logic        hold;
  logic        active;
  logic        running;
  logic        conv_done;
  logic        done_evt;
  logic [14:0] osr_last;

  function automatic sdadc_pkg::sdadc_mode_t mode_of(
    input logic o,
    input logic sl,
    input logic r
  );
    if (o) begin
      mode_of = sdadc_pkg::SDADC_PDN;
    end else if (sl) begin
      mode_of = sdadc_pkg::SDADC_SLEEP;
    end else if (r) begin
      mode_of = sdadc_pkg::SDADC_FRESET;
    end else begin
      mode_of = sdadc_pkg::SDADC_NORMAL;
    end
  endfunction

  function automatic logic wr_hit(
    input sdadc_pkg::sdadc_bus_t b,
    input logic [7:0]            ofs
  );
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  assign off  = s_q.ctrl0[`SDADC_B_OFF];
  assign slp  = s_q.ctrl0[`SDADC_B_SLP];
  assign frst = s_q.ctrl0[`SDADC_B_FRST];
  assign hold = s_q.ctrl1[`SDADC_B_HOLD];

  always_comb begin
    mode = mode_of(off, slp, frst);
  end

  assign active = (mode == sdadc_pkg::SDADC_NORMAL) ||
                  (mode == sdadc_pkg::SDADC_FRESET);

  // gating of analog sections per mode
  always_comb begin
    power.regulator   = s_q.pwr[`SDADC_B_LDO];
    power.bandgap     = s_q.pwr[`SDADC_B_LDO] | ~off;
    power.pga         = ~off;
    power.modulator   = active;
    power.filter_en   = ~off;
    power.filter_rst  = (mode == sdadc_pkg::SDADC_FRESET);
    power.mid_ref     = active & s_q.pwr[`SDADC_B_VCM];
    power.temp_sensor = active & ((s_q.chan[2:0] == `SDADC_TEMP_CHAN) |
                        (s_q.chan[5:`SDADC_B_CHN] == `SDADC_TEMP_CHAN));
    power.neg_buf     = active & s_q.ctrl1[`SDADC_B_NBUF];
    power.pos_buf     = active & s_q.ctrl1[`SDADC_B_PBUF];
    power.ref_ext     = s_q.ctrl0[`SDADC_B_REFSEL];
  end

  // divider free-runs unless powered down, so the tick is ready at release
  assign mclk_tick = ~off & ((s_q.clksel == `SDADC_DIV_BYPASS) |
                     (s_q.div_cnt == {s_q.clksel, 1'b1}));

  assign osr_last = 15'(`SDADC_OSR_MAX >> s_q.ctrl0[4:`SDADC_B_OSR]) - 15'h0001;
  assign running  = (mode == sdadc_pkg::SDADC_NORMAL) && s_q.started;
  assign conv_done = running && mclk_tick && (s_q.osr_cnt == osr_last);
  assign done_evt  = conv_done && !hold;

  always_comb begin
    s_d = s_q;
    if (wr_hit(bus, `SDADC_OFS_CTRL0)) begin
      s_d.ctrl0 = bus.wdata & `SDADC_CTRL0_MASK;
    end
    if (wr_hit(bus, `SDADC_OFS_CTRL1)) begin
      s_d.ctrl1 = {bus.wdata[7:1], 1'b0};
    end
    // a completion in the write cycle wins over a clearing write
    s_d.ctrl1[`SDADC_B_DONE] = s_d.ctrl1[`SDADC_B_DONE] | done_evt;
    if (wr_hit(bus, `SDADC_OFS_CLKSEL)) begin
      s_d.clksel = bus.wdata[4:0];
    end
    if (wr_hit(bus, `SDADC_OFS_PWR)) begin
      s_d.pwr = bus.wdata[4:0];
    end
    s_d.pwr[`SDADC_B_IRQF] = s_d.pwr[`SDADC_B_IRQF] | done_evt;
    if (wr_hit(bus, `SDADC_OFS_CHAN)) begin
      s_d.chan = bus.wdata[5:0];
    end
    if (done_evt) begin
      s_d.result = filter_word;
    end
    if (mclk_tick || off) begin
      s_d.div_cnt = 6'h00;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 6'h01;
    end
    // falling edge of filter reset in normal mode starts conversions
    s_d.frst_prev = frst;
    s_d.started   = (mode == sdadc_pkg::SDADC_NORMAL) &&
                    (s_q.started || s_q.frst_prev);
    if (!running) begin
      s_d.osr_cnt = 15'h0000;
    end else if (mclk_tick) begin
      s_d.osr_cnt = conv_done ? 15'h0000 : s_q.osr_cnt + 15'h0001;
    end
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `SDADC_OFS_CTRL0:   s_d.rdata = s_q.ctrl0;
        `SDADC_OFS_CTRL1:   s_d.rdata = s_q.ctrl1;
        `SDADC_OFS_CLKSEL:  s_d.rdata = {3'h0, s_q.clksel};
        `SDADC_OFS_RES_LO:  s_d.rdata = s_q.result[7:0];
        `SDADC_OFS_RES_MID: s_d.rdata = s_q.result[15:8];
        `SDADC_OFS_RES_HI:  s_d.rdata = s_q.result[23:16];
        `SDADC_OFS_PWR:     s_d.rdata = {3'h0, s_q.pwr};
        `SDADC_OFS_CHAN:    s_d.rdata = {2'h0, s_q.chan};
        default:            s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q           <= '0;
      s_q.ctrl0     <= `SDADC_CTRL0_RST;
      s_q.ctrl1     <= `SDADC_CTRL1_RST;
      s_q.clksel    <= `SDADC_CLKSEL_RST;
      s_q.pwr       <= `SDADC_PWR_RST;
      s_q.chan      <= `SDADC_CHAN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata       = s_q.rdata;
  assign result_word = s_q.result;
  assign irq = s_q.pwr[`SDADC_B_IRQF] & s_q.pwr[`SDADC_B_GIE] & s_q.pwr[`SDADC_B_IE];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  chk_pdn_override: assert property (
    off |-> (mode == sdadc_pkg::SDADC_PDN) && !power.modulator && !power.pga &&
            !power.filter_en && !power.mid_ref && !power.pos_buf && !power.neg_buf)
    else $error("power-off did not shut converter down");

  chk_sleep_gating: assert property (
    (!off && slp) |-> power.pga && power.filter_en && power.bandgap &&
                      !power.modulator && !power.mid_ref && !power.temp_sensor &&
                      !power.pos_buf && !power.neg_buf)
    else $error("sleep gating wrong");

  chk_normal_run: assert property (
    (!off && !slp && !frst) |-> (mode == sdadc_pkg::SDADC_NORMAL) &&
                                power.modulator && !power.filter_rst)
    else $error("normal mode not running");

  chk_freset_hold: assert property (
    (mode == sdadc_pkg::SDADC_FRESET) |-> power.filter_rst && power.modulator
                                          ##1 (s_q.osr_cnt == 15'h0000))
    else $error("filter reset did not discard conversion");

  chk_done_set: assert property (
    (conv_done && !hold) |=> s_q.ctrl1[`SDADC_B_DONE] && s_q.pwr[`SDADC_B_IRQF] &&
                             (result_word == $past(filter_word)))
    else $error("completion did not set flags and result");

  chk_irq_path: assert property (
    (conv_done && !hold && s_q.pwr[`SDADC_B_GIE] && s_q.pwr[`SDADC_B_IE] &&
     !wr_hit(bus, `SDADC_OFS_PWR)) |=> irq)
    else $error("enabled completion gave no interrupt");

  chk_done_sticky: assert property (
    (s_q.ctrl1[`SDADC_B_DONE] && !wr_hit(bus, `SDADC_OFS_CTRL1)) |=>
      s_q.ctrl1[`SDADC_B_DONE])
    else $error("done flag dropped without a write");

  chk_hold_freeze: assert property (
    (hold && !s_q.ctrl1[`SDADC_B_DONE]) |=> $stable(result_word) &&
                                            !s_q.ctrl1[`SDADC_B_DONE])
    else $error("held result changed or done set");

  // a write in the gap cycle retunes the divider, so both cycles exclude it
  chk_div_period: assert property (
    (mclk_tick && s_q.clksel == 5'h00 && !off &&
     !wr_hit(bus, `SDADC_OFS_CLKSEL) && !wr_hit(bus, `SDADC_OFS_CTRL0)) ##1
    (!wr_hit(bus, `SDADC_OFS_CLKSEL) && !wr_hit(bus, `SDADC_OFS_CTRL0)) |->
      !mclk_tick ##1 mclk_tick)
    else $error("divide-by-two tick spacing wrong");

  // gating and timing checks the bench reaches only indirectly
  chk_midref_follow: assert property (
    (!off && !slp) |-> (power.mid_ref == s_q.pwr[`SDADC_B_VCM]))
    else $error("mid ref ignores its enable");

  chk_temp_pos: assert property (
    (!off && !slp && (s_q.chan[2:0] == `SDADC_TEMP_CHAN)) |-> power.temp_sensor)
    else $error("temperature sensor off though selected");

  chk_temp_neg: assert property (
    (!off && !slp && (s_q.chan[5:`SDADC_B_CHN] == `SDADC_TEMP_CHAN)) |-> power.temp_sensor)
    else $error("temperature sensor off though selected");

  chk_temp_idle: assert property (
    ((s_q.chan[2:0] != `SDADC_TEMP_CHAN) &&
     (s_q.chan[5:`SDADC_B_CHN] != `SDADC_TEMP_CHAN)) |-> !power.temp_sensor)
    else $error("temperature sensor on though not selected");

  chk_buf_follow: assert property (
    (!off && !slp) |-> (power.neg_buf == s_q.ctrl1[`SDADC_B_NBUF]) &&
                       (power.pos_buf == s_q.ctrl1[`SDADC_B_PBUF]))
    else $error("reference buffer ignores its enable");

  chk_ref_route: assert property (
    power.ref_ext == s_q.ctrl0[`SDADC_B_REFSEL])
    else $error("reference pair select not routed");

  chk_hold_no_irq: assert property (
    (hold && !s_q.pwr[`SDADC_B_IRQF] && !wr_hit(bus, `SDADC_OFS_PWR)) |=>
      !s_q.pwr[`SDADC_B_IRQF])
    else $error("interrupt flag set during hold");

  chk_result_only_done: assert property (
    !done_evt |=> $stable(result_word))
    else $error("result changed without completion");

  chk_irq_gate: assert property (
    irq |-> s_q.pwr[`SDADC_B_GIE] && s_q.pwr[`SDADC_B_IE])
    else $error("interrupt raised while masked");

  chk_osr_short: assert property (
    (conv_done && (s_q.ctrl0[4:`SDADC_B_OSR] == 3'h7)) |->
      (s_q.osr_cnt == 15'h007F))
    else $error("code 7 conversion not 128 ticks");

  chk_osr_mid: assert property (
    (conv_done && (s_q.ctrl0[4:`SDADC_B_OSR] == 3'h5)) |->
      (s_q.osr_cnt == 15'h01FF))
    else $error("code 5 conversion not 512 ticks");

  chk_div_bypass: assert property (
    (!off && (s_q.clksel == `SDADC_DIV_BYPASS)) |-> mclk_tick)
    else $error("bypass code did not pass clock through");

  chk_tick_off: assert property (
    off |-> !mclk_tick)
    else $error("converter clock ran while powered off");

  chk_filter_rst_only: assert property (
    power.filter_rst |-> (mode == sdadc_pkg::SDADC_FRESET))
    else $error("filter reset outside reset mode");

  chk_pdn_stop: assert property (
    off |=> !s_q.started && (s_q.osr_cnt == 15'h0000))
    else $error("conversion kept running in power-down");

endmodule

// File: bench/sdadc_mod_model.sv
// behavioural modulator and decimation datapath feeding the mode control
// assumes mclk_tick and the modulator power level come from the control block
module sdadc_mod_model (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        mclk_tick,
  input  wire logic        mod_on,
  output logic [23:0]      filter_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // unpowered output toggles so a stale word can never look valid
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      filter_word <= 24'h7FFF00;
    else if (!mod_on)
      filter_word <= ~filter_word;
    else if (mclk_tick)
      filter_word <= filter_word + 24'h000007;
  end
endmodule

// File: bench/sdadc_mode_ctrl_tb_top.sv
// self-checking bench for the converter mode control
// assumes params header, package, design and modulator model compiled first
`include "sdadc_params.svh"
module sdadc_mode_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    sys_clk;
  logic                    nrst;
  sdadc_pkg::sdadc_bus_t   bus;
  logic [7:0]              rdata;
  logic [23:0]             filter_word;
  logic                    mclk_tick;
  sdadc_pkg::sdadc_power_t power;
  sdadc_pkg::sdadc_mode_t  mode;
  logic [23:0]             result_word;
  logic                    irq;
  int                      err_count;
  int                      tests_run;
  int                      cycles;
  logic [23:0]             tick_cnt, prev_fw, last_res, exp_res, conv_gap, gap_seen, t0;
  logic [7:0]              v;
  logic [4:0]              codes [4] = '{5'h00, 5'h01, 5'h1E, 5'h1F};

  sdadc_mode_ctrl sdadc_mode_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst), .bus(bus),
    .rdata(rdata), .filter_word(filter_word), .mclk_tick(mclk_tick), .power(power),
    .mode(mode), .result_word(result_word), .irq(irq));
  sdadc_mod_model sdadc_mod_model_inst (.sys_clk(sys_clk), .nrst(nrst),
    .mclk_tick(mclk_tick), .mod_on(power.modulator), .filter_word(filter_word));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // monitor: result must be the word present in the completion cycle
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    prev_fw <= filter_word;
    conv_gap <= conv_gap + 24'h000001;
    if (mclk_tick === 1'b1)
      tick_cnt <= tick_cnt + 24'h000001;
    if (result_word !== last_res) begin
      last_res <= result_word;
      exp_res <= prev_fw;
      gap_seen <= conv_gap;
      conv_gap <= 24'h000001;
      chk("result_word", prev_fw, result_word);
    end
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic get(input logic [7:0] a);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] ex, input string nm);
    get(a);
    chk(nm, {16'h0, ex}, {16'h0, v});
  endtask

  task automatic mcase(input logic [7:0] c0, pw, c1, ch, input logic [3:0] em,
                       input logic [10:0] ep);
    wr(`SDADC_OFS_PWR, pw);
    wr(`SDADC_OFS_CTRL1, c1);
    wr(`SDADC_OFS_CHAN, ch);
    wr(`SDADC_OFS_CTRL0, c0);
    #1;
    chk("mode", {20'h0, em}, {20'h0, mode});
    chk("power", {13'h0, ep}, {13'h0, power});
  endtask

  task automatic start(input logic [2:0] c);
    wr(`SDADC_OFS_CTRL0, {3'h4, c, 2'h0});
    wr(`SDADC_OFS_CTRL0, {3'h0, c, 2'h0});
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 400 && irq !== 1'b1; i++)
      @(posedge sys_clk);
    chk("irq", 24'h1, {23'h0, irq});
  endtask

  initial begin
    nrst = 1'b0;
    bus = '0;
    {err_count, tests_run, cycles} = '0;
    {tick_cnt, last_res, exp_res, conv_gap, gap_seen} = '0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    chk("power", 24'h0, {13'h0, power});
    rdc(`SDADC_OFS_CTRL0, 8'h20, "ctrl0");
    for (int a = 1; a < 9; a++)
      rdc(a[7:0], 8'h00, "reset value");
    wr(`SDADC_OFS_RES_LO, 8'hAA);
    wr(8'h08, 8'h55);
    rdc(`SDADC_OFS_RES_LO, 8'h00, "result lo");
    rdc(8'h08, 8'h00, "unmapped");
    mcase(8'h20, 8'h03, 8'h18, 8'h07, 4'h1, 11'h600);
    mcase(8'hE0, 8'h03, 8'h18, 8'h07, 4'h1, 11'h600);
    mcase(8'hE0, 8'h00, 8'h18, 8'h07, 4'h1, 11'h000);
    mcase(8'h40, 8'h03, 8'h18, 8'h07, 4'h2, 11'h684);
    mcase(8'hC0, 8'h03, 8'h18, 8'h07, 4'h2, 11'h684);
    mcase(8'h00, 8'h03, 8'h18, 8'h07, 4'h4, 11'h7FC);
    mcase(8'h80, 8'h03, 8'h18, 8'h07, 4'h8, 11'h7FE);
    mcase(8'h00, 8'h00, 8'h00, 8'h00, 4'h4, 11'h4C4);
    mcase(8'h01, 8'h00, 8'h00, 8'h38, 4'h4, 11'h4E5);
    for (int k = 0; k < 4; k++) begin
      wr(`SDADC_OFS_CLKSEL, {3'h0, codes[k]});
      repeat (64) @(posedge sys_clk);
      t0 = tick_cnt;
      repeat (4 * ((codes[k] == 5'h1F) ? 1 : 2 * (codes[k] + 1))) @(posedge sys_clk);
      chk("ticks", 24'h4, tick_cnt - t0);
    end
    wr(`SDADC_OFS_CTRL0, 8'h20);
    // the write edge itself still counts a tick
    @(posedge sys_clk);
    t0 = tick_cnt;
    repeat (20) @(posedge sys_clk);
    chk("ticks off", t0, tick_cnt);
    wr(`SDADC_OFS_PWR, 8'h0D);
    wr(`SDADC_OFS_CTRL1, 8'h00);
    wr(`SDADC_OFS_CLKSEL, 8'h1F);
    wr(`SDADC_OFS_CTRL0, 8'h3C);
    start(3'h7);
    wait_irq();
    rdc(`SDADC_OFS_CTRL1, 8'h02, "done");
    wr(`SDADC_OFS_CTRL1, 8'h04);
    rdc(`SDADC_OFS_PWR, 8'h1D, "irq flag");
    rdc(`SDADC_OFS_RES_LO, exp_res[7:0], "res lo");
    rdc(`SDADC_OFS_RES_MID, exp_res[15:8], "res mid");
    rdc(`SDADC_OFS_RES_HI, exp_res[23:16], "res hi");
    t0 = exp_res;
    wr(`SDADC_OFS_PWR, 8'h0D);
    repeat (300) @(posedge sys_clk);
    chk("held", t0, result_word);
    chk("irq held", 24'h0, {23'h0, irq});
    rdc(`SDADC_OFS_CTRL1, 8'h04, "done held");
    wr(`SDADC_OFS_CTRL1, 8'h00);
    wait_irq();
    wr(`SDADC_OFS_PWR, 8'h05);
    wr(`SDADC_OFS_CTRL1, 8'h00);
    v = 8'h00;
    for (int i = 0; i < 200 && v[1] !== 1'b1; i++)
      get(`SDADC_OFS_CTRL1);
    chk("polled done", 24'h1, {23'h0, v[1]});
    chk("irq masked", 24'h0, {23'h0, irq});
    rdc(`SDADC_OFS_PWR, 8'h15, "irq flag");
    wr(`SDADC_OFS_PWR, 8'h1D);
    #1 chk("irq both", 24'h1, {23'h0, irq});
    wr(`SDADC_OFS_PWR, 8'h19);
    #1 chk("irq ie off", 24'h0, {23'h0, irq});
    rdc(`SDADC_OFS_CTRL1, 8'h02, "done sticky");
    for (int c = 7; c > 4; c--) begin
      start(c[2:0]);
      repeat (2 * (16384 >> c) + 20) @(posedge sys_clk);
      chk("osr gap", 24'(16384 >> c), gap_seen);
    end
    close_out();
  end
endmodule
